// ==== core/sseiu_consts.vh ====
// constants of the status event and interrupt unit
`ifndef SSEIU_CONSTS_VH
`define SSEIU_CONSTS_VH

// register addresses as carried in the datagram address byte
`define SSEIU_ADDR_GLOBAL_CONF   7'h00
`define SSEIU_ADDR_SPI_SELECT    7'h0b
`define SSEIU_ADDR_CLEAR_EXEMPT  7'h0c
`define SSEIU_ADDR_IRQ_SELECT    7'h0d
`define SSEIU_ADDR_EVENT_LATCH   7'h0e
`define SSEIU_ADDR_CONDITION     7'h0f

// reset values
`define SSEIU_RST_GLOBAL_CONF    32'h0000_0000
`define SSEIU_RST_SPI_SELECT     32'h0000_0000
`define SSEIU_RST_CLEAR_EXEMPT   32'h0000_0000
`define SSEIU_RST_IRQ_SELECT     32'h0000_0000
`define SSEIU_RST_EVENT_LATCH    32'h0000_0000

// global configuration field positions
`define SSEIU_GC_SHARED_EN_BIT   15
`define SSEIU_GC_IRQ_POL_BIT     29
`define SSEIU_GC_WIRED_AND_BIT   30

// datagram layout
`define SSEIU_DGRAM_BITS         40
`define SSEIU_DGRAM_CNT_W        6
`define SSEIU_DGRAM_WRITE_BIT    39
`define SSEIU_DGRAM_ADDR_HI      38
`define SSEIU_DGRAM_ADDR_LO      32
`define SSEIU_STATUS_BITS        8

// event positions of the velocity phase values, then the first external event
`define SSEIU_EV_VEL_00          0
`define SSEIU_EV_VEL_01          1
`define SSEIU_EV_VEL_10          2
`define SSEIU_EV_FIRST_EXT       3

`endif

// ==== core/sseiu_status_pick.v ====
// picks the eight lowest selected events for the spi status byte
`timescale 1ns/100ps
`include "sseiu_consts.vh"

module sseiu_status_pick #(
  parameter EV_W = 32
) (
  // clock and reset
  input  wire                          core_clk,
  input  wire                          reset,
  // event and selection
  input  wire [EV_W-1:0]               events,
  input  wire [EV_W-1:0]               select,
  // packed status byte
  output reg  [`SSEIU_STATUS_BITS-1:0] status_r
);

  // rank of each event among the selected ones below it
  wire [6:0]                           rank [0:EV_W];
  // one hit vector per status bit
  wire [`SSEIU_STATUS_BITS*EV_W-1:0]   hit;
  wire [`SSEIU_STATUS_BITS-1:0]        status_nxt;

  assign rank[0] = 7'h00;

  genvar i, j;
  generate
    // running count keeps event order, lowest index first
    for (i = 0; i < EV_W; i = i + 1)
    begin : g_rank
      assign rank[i+1] = rank[i] + {6'h00, select[i]};
    end
    // status bit j takes the selected event of rank j
    for (j = 0; j < `SSEIU_STATUS_BITS; j = j + 1)
    begin : g_bit
      for (i = 0; i < EV_W; i = i + 1)
      begin : g_ev
        assign hit[j*EV_W+i] = select[i] & events[i] & (rank[i] == j); // RL13
      end
      assign status_nxt[j] = |hit[j*EV_W +: EV_W]; // RL12
    end
  endgenerate

  // registered so the shifter loads a stable byte
  always @(posedge core_clk)
  begin
    if (reset)
      status_r <= 8'h00;
    else
      status_r <= status_nxt;
  end

endmodule // sseiu_status_pick

// ==== core/sseiu_top.v ====
// status flag, event latch, spi register access and interrupt pin
// Behaviour
// (RL1) status change sets its event bit
// (RL2) event stays set until cleared
// (RL3) condition register shows live status
// (RL4) one event per velocity phase value
// (RL5) group change events, events without flags
// (RL6) thirty two events in one register
// (RL7) reading events clears them
// (RL8) exempt mask bits survive the read
// (RL9) writing one clears that event
// (RL10) host reads events once before operation
// (RL11) host knows near-read events may vanish
// (RL12) selected events lead every spi response
// (RL13) eight lowest selected events, order kept
// (RL14) interrupt is or of selected events
// (RL15) configuration bits 15, 29, 30 exist
// (RL16) interrupt active low unless polarity set
// (RL17) shared line uses weak/strong drive
// (RL18) eight clock transfer returns status too
// (RL19) new event beats simultaneous clear
// (RL20) detection compares with previous cycle
`timescale 1ns/100ps
`include "sseiu_consts.vh"

module sseiu_top #(
  parameter EV_W        = 32,
  parameter EXT_ANYEDGE = 32'h0000_0000  // ext events that fire on any change
) (
  // clock and reset
  input  wire            core_clk,
  input  wire            reset,
  // spi pins from the host
  input  wire            spi_cs_n_in,
  input  wire            spi_sck_in,
  input  wire            spi_sdi_in,
  output reg             spi_sdo_r,
  // status from the motion core
  input  wire [31:0]     status_flags_in,
  input  wire [1:0]      velocity_phase_flag,
  input  wire [EV_W-1:0] event_source_in,
  // interrupt pin
  output reg             irq_out_r,
  output wire            irq_oe,
  output reg             irq_strong_r
);

  // pin synchronisers, first stage read only by second
  reg        cs_s1_r;
  reg        cs_s2_r;
  reg        cs_s3_r;
  reg        sck_s1_r;
  reg        sck_s2_r;
  reg        sck_s3_r;
  reg        sdi_s1_r;
  reg        sdi_s2_r;
  // spi shifters
  reg [`SSEIU_DGRAM_BITS-1:0]  rx_r;
  reg [`SSEIU_DGRAM_BITS-1:0]  tx_r;
  reg [`SSEIU_DGRAM_CNT_W-1:0] bit_cnt_r;
  reg [31:0]                   rd_data_r;
  // registers
  reg [31:0]     gconf_r;
  reg [31:0]     spi_sel_r;
  reg [31:0]     exempt_r;
  reg [31:0]     irq_sel_r;
  reg [EV_W-1:0] events_r;
  reg [EV_W-1:0] events_nxt;
  // previous cycle copy for edge detection, and the unregistered irq level
  reg [EV_W-1:0] cond_prev_r;
  reg            irq_nxt;
  // status byte from the picker
  wire [`SSEIU_STATUS_BITS-1:0] status_byte;

  // pin edges seen on the synchronised copies
  wire sck_rise = sck_s2_r & ~sck_s3_r;
  wire sck_fall = ~sck_s2_r & sck_s3_r;
  wire cs_fall  = ~cs_s2_r & cs_s3_r;
  wire cs_rise  = cs_s2_r & ~cs_s3_r;
  wire cs_act   = ~cs_s2_r;

  // command decode, valid only with a full datagram
  wire       dgram_ok = cs_rise & (bit_cnt_r == `SSEIU_DGRAM_BITS);
  wire       cmd_wr   = rx_r[`SSEIU_DGRAM_WRITE_BIT];
  wire [6:0] cmd_addr = rx_r[`SSEIU_DGRAM_ADDR_HI:`SSEIU_DGRAM_ADDR_LO];
  wire [31:0] cmd_data = rx_r[31:0];
  wire       do_write = dgram_ok & cmd_wr;
  wire       do_read  = dgram_ok & ~cmd_wr;

  // event conditions: velocity phase values plus external sources
  wire [EV_W-1:0] cond_now;
  wire [EV_W-1:0] ev_set;
  wire [EV_W-1:0] ev_clr;

  assign cond_now[`SSEIU_EV_VEL_00] = (velocity_phase_flag == 2'h0); // RL4
  assign cond_now[`SSEIU_EV_VEL_01] = (velocity_phase_flag == 2'h1); // RL4
  assign cond_now[`SSEIU_EV_VEL_10] = (velocity_phase_flag == 2'h2); // RL4
  assign cond_now[EV_W-1:`SSEIU_EV_FIRST_EXT] = event_source_in[EV_W-1:`SSEIU_EV_FIRST_EXT];

  genvar k;
  generate
    // per event: rising or any-change detection against last cycle
    for (k = 0; k < EV_W; k = k + 1)
    begin : g_det
      if (k >= `SSEIU_EV_FIRST_EXT && EXT_ANYEDGE[k])
      begin : g_any
        assign ev_set[k] = cond_now[k] ^ cond_prev_r[k]; // RL5 RL20
      end
      else
      begin : g_rise
        assign ev_set[k] = cond_now[k] & ~cond_prev_r[k]; // RL1 RL20
      end
    end
  endgenerate

  // clears: read of the latch (not exempt) or write of ones
  assign ev_clr =
    ({EV_W{do_read & (cmd_addr == `SSEIU_ADDR_EVENT_LATCH)}} & ~exempt_r) | // RL7 RL8
    ({EV_W{do_write & (cmd_addr == `SSEIU_ADDR_EVENT_LATCH)}} & cmd_data);  // RL9

  // sticky latch, set wins over clear
  always @*
  begin
    events_nxt = (events_r & ~ev_clr) | ev_set; // RL2 RL19
  end

  // synchronisers and edge history
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      cs_s3_r  <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end
    else
    begin
      cs_s1_r  <= spi_cs_n_in;
      cs_s2_r  <= cs_s1_r;
      cs_s3_r  <= cs_s2_r;
      sck_s1_r <= spi_sck_in;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      sdi_s1_r <= spi_sdi_in;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // receive shifter and saturating bit count
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      rx_r      <= 40'h00_0000_0000;
      bit_cnt_r <= 6'h00;
    end
    else if (cs_fall)
      bit_cnt_r <= 6'h00;         // new frame
    else if (cs_act && sck_rise)
    begin
      // longer frames keep only the last forty bits
      rx_r <= {rx_r[`SSEIU_DGRAM_BITS-2:0], sdi_s2_r};
      if (bit_cnt_r != `SSEIU_DGRAM_BITS)
        bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // transmit shifter: status byte first, then prior read data
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      tx_r      <= 40'h00_0000_0000;
      spi_sdo_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      tx_r      <= {status_byte, rd_data_r};           // RL12 RL18
      spi_sdo_r <= status_byte[`SSEIU_STATUS_BITS-1];  // RL18
    end
    else if (cs_act && sck_fall)
    begin
      // received bits follow for daisy chained parts
      tx_r      <= {tx_r[`SSEIU_DGRAM_BITS-2:0], rx_r[`SSEIU_DGRAM_BITS-1]};
      spi_sdo_r <= tx_r[`SSEIU_DGRAM_BITS-2];
    end
  end

  // read data latched at frame end, returned in the next frame
  always @(posedge core_clk)
  begin
    if (reset)
      rd_data_r <= 32'h0000_0000;
    else if (do_read)
    begin
      case (cmd_addr)
        `SSEIU_ADDR_GLOBAL_CONF:  rd_data_r <= gconf_r;
        `SSEIU_ADDR_SPI_SELECT:   rd_data_r <= spi_sel_r;
        `SSEIU_ADDR_CLEAR_EXEMPT: rd_data_r <= exempt_r;
        `SSEIU_ADDR_IRQ_SELECT:   rd_data_r <= irq_sel_r;
        `SSEIU_ADDR_EVENT_LATCH:  rd_data_r <= events_r;        // RL6
        `SSEIU_ADDR_CONDITION:    rd_data_r <= status_flags_in; // RL3
        default:                  rd_data_r <= 32'h0000_0000;   // unmapped reads zero
      endcase
    end
  end

  // writable registers
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      gconf_r   <= `SSEIU_RST_GLOBAL_CONF;
      spi_sel_r <= `SSEIU_RST_SPI_SELECT;
      exempt_r  <= `SSEIU_RST_CLEAR_EXEMPT;
      irq_sel_r <= `SSEIU_RST_IRQ_SELECT;
    end
    else if (do_write)
    begin
      case (cmd_addr)
        `SSEIU_ADDR_GLOBAL_CONF:  gconf_r   <= cmd_data; // RL15
        `SSEIU_ADDR_SPI_SELECT:   spi_sel_r <= cmd_data;
        `SSEIU_ADDR_CLEAR_EXEMPT: exempt_r  <= cmd_data;
        `SSEIU_ADDR_IRQ_SELECT:   irq_sel_r <= cmd_data;
        default:                  ;  // latch handled above, others ignored
      endcase
    end
  end

  // event latch and previous-cycle condition copy
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      events_r    <= `SSEIU_RST_EVENT_LATCH;
      // copy live levels so release of reset shows no false edge
      cond_prev_r <= cond_now;    // RL20
    end
    else
    begin
      events_r    <= events_nxt;  // RL6
      cond_prev_r <= cond_now;    // RL20
    end
  end

  // status byte packer
  sseiu_status_pick #(
    .EV_W     (EV_W)
  ) u_pick (
    .core_clk (core_clk),
    .reset    (reset),
    .events   (events_r),
    .select   (spi_sel_r),
    .status_r (status_byte)
  );

  // interrupt: or of selected events, then polarity
  always @*
  begin
    irq_nxt = |(events_r & irq_sel_r); // RL14
  end

  // pin level and drive strength
  // wired modes rely on a pull elsewhere; strength is reported, not made here
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_out_r    <= 1'b1;  // inactive, active low by default
      irq_strong_r <= 1'b1;
    end
    else
    begin
      irq_out_r <= irq_nxt ^ ~gconf_r[`SSEIU_GC_IRQ_POL_BIT]; // RL16
      if (!gconf_r[`SSEIU_GC_SHARED_EN_BIT])
        irq_strong_r <= 1'b1;
      else if (gconf_r[`SSEIU_GC_WIRED_AND_BIT])
        irq_strong_r <= ~irq_nxt;  // RL17
      else
        irq_strong_r <= irq_nxt;   // RL17
    end
  end

  // pin always driven; weak drive is still drive
  assign irq_oe = 1'b1;

endmodule // sseiu_top

// ==== verification/sseiu_checker.sv ====
// pin-level assertion checker for the status event unit
`timescale 1ns/100ps
module sseiu_checker #(parameter EV_W = 32) (
  // watched pins
  input wire            core_clk,
  input wire            reset,
  input wire            spi_cs_n_in,
  input wire            spi_sck_in,
  input wire            spi_sdi_in,
  input wire            spi_sdo_r,
  input wire [31:0]     status_flags_in,
  input wire [1:0]      velocity_phase_flag,
  input wire [EV_W-1:0] event_source_in,
  input wire            irq_out_r,
  input wire            irq_oe,
  input wire            irq_strong_r
);
  reg  [3:0] cs_hi_r;   // cycles since the last frame
  reg  [2:0] src_q_r;   // cycles of steady event sources
  wire       calm = (cs_hi_r == 4'hf) && (src_q_r == 3'h7);
  // quiet counters; a command lands 3 cycles after cs rises, so wait longer
  always @(posedge core_clk)
  begin
    cs_hi_r <= (reset || !spi_cs_n_in) ? 4'h0 : cs_hi_r + {3'h0, cs_hi_r != 4'hf};
    src_q_r <= (reset || !$stable(event_source_in) || !$stable(velocity_phase_flag))
               ? 3'h0 : src_q_r + {2'h0, src_q_r != 3'h7};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_oe_always: assert property (irq_oe)
    else $error("irq pin not driven");
  chk_sdo_reset: assert property (disable iff (1'b0) reset |=> !spi_sdo_r)
    else $error("sdo not low in reset");
  chk_irq_reset: assert property (disable iff (1'b0) reset |=> irq_out_r && irq_strong_r)
    else $error("irq pin not inactive strong in reset");
  chk_irq_start: assert property ($fell(reset) |-> irq_out_r ##1 irq_out_r)
    else $error("irq active right after reset");
  chk_irq_holds: assert property (calm |-> $stable(irq_out_r))
    else $error("irq moved with no cause");
  chk_strong_holds: assert property (calm |-> $stable(irq_strong_r))
    else $error("drive strength moved with no cause");
  chk_strong_follows: assert property ($changed(irq_strong_r) && cs_hi_r == 4'hf
    |-> $changed(irq_out_r))
    else $error("drive strength moved without level");
  chk_sdo_low_sck: assert property ($changed(spi_sdo_r) |-> !spi_sck_in)
    else $error("sdo moved while sck high");
endmodule // sseiu_checker

bind sseiu_top sseiu_checker #(.EV_W(EV_W)) u_sseiu_checker (
  .core_clk(core_clk), .reset(reset), .spi_cs_n_in(spi_cs_n_in),
  .spi_sck_in(spi_sck_in), .spi_sdi_in(spi_sdi_in), .spi_sdo_r(spi_sdo_r),
  .status_flags_in(status_flags_in), .velocity_phase_flag(velocity_phase_flag),
  .event_source_in(event_source_in), .irq_out_r(irq_out_r), .irq_oe(irq_oe),
  .irq_strong_r(irq_strong_r));

// ==== verification/sseiu_host_model.sv ====
// host spi master model driving the event unit
`timescale 1ns/100ps
module sseiu_host_model (
  // clock and spi pins
  input  wire core_clk,
  output reg  spi_cs_n,
  output reg  spi_sck,
  output reg  spi_sdi,
  input  wire spi_sdo
);
  localparam HALF = 5;  // core cycles per sck half, above the quarter-rate limit
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_sdi  = 1'b0;
  end
  // moves only at falling core edges
  task tick(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // one msb-first frame of n bits; fewer than 40 gives a status-only frame
  task xfer(input integer n, input [39:0] tx, output [39:0] rx);
    integer i;
    begin
      rx = 40'h00_0000_0000;
      tick(1);
      spi_cs_n = 1'b0;
      tick(HALF);
      for (i = 39; i > 39 - n; i = i - 1)
      begin
        spi_sdi = tx[i];
        tick(HALF);
        spi_sck = 1'b1;
        rx[i]   = spi_sdo;  // settled since the previous fall
        tick(HALF);
        spi_sck = 1'b0;
      end
      tick(HALF);
      spi_cs_n = 1'b1;
      spi_sdi  = ~spi_sdi;  // released line shows no stale bit
      tick(8);  // gap covers the command landing
    end
  endtask
endmodule // sseiu_host_model

// ==== verification/sseiu_top_tb.sv ====
// self-checking bench for the status event unit
`timescale 1ns/100ps
`include "sseiu_consts.vh"
module sseiu_top_tb;
  localparam [6:0] A_GC = `SSEIU_ADDR_GLOBAL_CONF;
  localparam [6:0] A_EV = `SSEIU_ADDR_EVENT_LATCH;
  reg         core_clk, reset;
  reg  [31:0] status_flags_in, event_source_in, rd_data;
  reg  [1:0]  velocity_phase_flag;
  reg  [39:0] rx;
  integer     miscompares, comparisons, i;
  wire        spi_cs_n, spi_sck, spi_sdi, spi_sdo_r, irq_out_r, irq_oe, irq_strong_r;

  sseiu_top #(.EV_W(32), .EXT_ANYEDGE(32'h0000_0040)) u_sseiu_top (
    .core_clk(core_clk), .reset(reset), .spi_cs_n_in(spi_cs_n), .spi_sck_in(spi_sck),
    .spi_sdi_in(spi_sdi), .spi_sdo_r(spi_sdo_r), .status_flags_in(status_flags_in),
    .velocity_phase_flag(velocity_phase_flag), .event_source_in(event_source_in),
    .irq_out_r(irq_out_r), .irq_oe(irq_oe), .irq_strong_r(irq_strong_r));
  sseiu_host_model u_sseiu_host_model (.core_clk(core_clk), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo_r));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task give_verdict;
  begin
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task chk_val(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task chk_pin(input got, input exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task wr(input [6:0] a, input [31:0] d);
    u_sseiu_host_model.xfer(40, {1'b1, a, d}, rx);
  endtask
  // read data comes back in the following frame
  task rd(input [6:0] a);
  begin
    u_sseiu_host_model.xfer(40, {1'b0, a, 32'h0000_0000}, rx);
    u_sseiu_host_model.xfer(40, {1'b0, 7'h01, 32'h0000_0000}, rx);
    rd_data = rx[31:0];
  end
  endtask
  // new source level, then room for event and irq latency
  task src(input [31:0] v);
  begin
    event_source_in = v;
    repeat (4) @(negedge core_clk);
  end
  endtask

  initial
  begin
    miscompares = 0;
    comparisons = 0;
    reset = 1'b1;
    status_flags_in = 32'h0000_0000;
    event_source_in = 32'h0000_0000;
    velocity_phase_flag = 2'h0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_pin(irq_out_r, 1'b1);
    rd(A_EV);
    chk_val(rd_data, 32'h0000_0000);
    // masks start clear and keep what is written
    for (i = 11; i < 14; i = i + 1)
    begin
      rd(i[6:0]);
      chk_val(rd_data, 32'h0000_0000);
      wr(i[6:0], 32'h5a00_00a5 ^ i[31:0]);
      rd(i[6:0]);
      chk_val(rd_data, 32'h5a00_00a5 ^ i[31:0]);
      wr(i[6:0], 32'h0000_0000);
    end
    wr(A_GC, 32'h6000_8000);
    rd(A_GC);
    chk_val(rd_data, 32'h6000_8000);
    wr(A_GC, 32'h0000_0000);
    rd(7'h01);
    chk_val(rd_data, 32'h0000_0000);
    // condition flags live, writes ignored
    status_flags_in = 32'ha5a5_0f0f;
    wr(`SSEIU_ADDR_CONDITION, 32'h0000_0000);
    rd(`SSEIU_ADDR_CONDITION);
    chk_val(rd_data, 32'ha5a5_0f0f);
    status_flags_in = 32'h0f0f_a5a5;
    rd(`SSEIU_ADDR_CONDITION);
    chk_val(rd_data, 32'h0f0f_a5a5);
    // each velocity phase entered once, plus source edges
    for (i = 1; i < 4; i = i + 1)
    begin
      velocity_phase_flag = (i == 3) ? 2'h0 : i[1:0];
      repeat (4) @(negedge core_clk);
    end
    src(32'h8000_0048);
    rd(A_EV);
    chk_val(rd_data, 32'h8000_004f);
    src(32'h0000_0000);
    rd(A_EV);
    chk_val(rd_data, 32'h0000_0040);
    // exempt bit survives the read, write-one clears it
    wr(`SSEIU_ADDR_CLEAR_EXEMPT, 32'h0000_0008);
    src(32'h0000_0018);
    src(32'h0000_0000);
    rd(A_EV);
    chk_val(rd_data, 32'h0000_0018);
    wr(A_EV, 32'h0000_0000);
    rd(A_EV);
    chk_val(rd_data, 32'h0000_0008);
    wr(A_EV, 32'h0000_0008);
    rd(A_EV);
    chk_val(rd_data, 32'h0000_0000);
    wr(`SSEIU_ADDR_CLEAR_EXEMPT, 32'h0000_0000);
    // source rises in the very cycle the write-one clear lands
    fork
      wr(A_EV, 32'h0000_0008);
      begin
        @(posedge spi_cs_n);
        repeat (2) @(negedge core_clk);
        event_source_in = 32'h0000_0008;
      end
    join
    rd(A_EV);
    chk_val(rd_data, 32'h0000_0008);
    // irq from selected events, polarity and shared drive
    wr(`SSEIU_ADDR_IRQ_SELECT, 32'h0000_0010);
    src(32'h0000_0020);
    chk_pin(irq_out_r, 1'b1);
    src(32'h0000_0010);
    chk_pin(irq_out_r, 1'b0);
    wr(A_GC, 32'h2000_8000);
    chk_pin(irq_out_r, 1'b1);
    chk_pin(irq_strong_r, 1'b1);
    wr(A_EV, 32'h0000_0010);
    chk_pin(irq_out_r, 1'b0);
    chk_pin(irq_strong_r, 1'b0);
    wr(A_GC, 32'h6000_8000);
    chk_pin(irq_strong_r, 1'b1);
    src(32'h0000_0000);
    src(32'h0000_0010);
    chk_pin(irq_strong_r, 1'b0);
    wr(A_GC, 32'h0000_0000);
    wr(`SSEIU_ADDR_IRQ_SELECT, 32'h0000_0000);
    rd(A_EV);
    // nine selected: lowest eight sent; short frame executes nothing
    wr(`SSEIU_ADDR_SPI_SELECT, 32'h8000_01fe);
    src(32'h8000_0128);
    u_sseiu_host_model.xfer(8, {1'b1, 7'h0d, 32'hffff_ffff}, rx);
    chk_val({24'h00_0000, rx[39:32]}, 32'h0000_0094);
    chk_pin(irq_out_r, 1'b1);
    u_sseiu_host_model.xfer(40, {1'b0, 7'h0b, 32'h0000_0000}, rx);
    chk_val({24'h00_0000, rx[39:32]}, 32'h0000_0094);
    give_verdict;
  end
  // hang guard, well past the expected run
  initial
  begin
    #500_000;
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule // sseiu_top_tb
